// ===== logic/aux_timer_pkg.sv
// Constants for the auxiliary up-count timer and its register slave.
// Assumes a 32-bit AXI4-Lite bus with byte addresses, address bits 7:2 decoded.
package aux_timer_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CMD     = 8'h04;
  localparam logic [7:0] OFS_STAT    = 8'h08;
  localparam logic [7:0] OFS_COUNT   = 8'h0C;
  localparam logic [7:0] OFS_PERIOD  = 8'h10;
  localparam logic [7:0] OFS_CMP     = 8'h14;
  localparam logic [7:0] OFS_CMP_SHD = 8'h18;
  // Control register fields
  localparam int CTL_SEL_LSB  = 0;
  localparam int CTL_DIV_BIT  = 3;
  localparam int CTL_SS_BIT   = 4;
  localparam int CTL_TRIG_LSB = 5;
  localparam int CTL_DIR_LSB  = 8;
  // Write-only command bits
  localparam int CMD_RUN_SET = 0;
  localparam int CMD_RUN_CLR = 1;
  localparam int CMD_CNT_CLR = 2;
  localparam int CMD_SHD_SET = 3;
  localparam int CMD_SHD_CLR = 4;
  // Status bits
  localparam int ST_RUN = 0;
  localparam int ST_SHD = 1;
  localparam int ST_ZM  = 2;
  localparam int ST_PM  = 3;
  localparam int ST_CM  = 4;
  // Reset values
  localparam logic [9:0]  RST_CTRL  = 10'h000;
  localparam logic [15:0] RST_VAL16 = 16'h0000;
  // Trigger source codes
  localparam logic [2:0] TRIG_NONE    = 3'h0;
  localparam logic [2:0] TRIG_CMP0    = 3'h1;
  localparam logic [2:0] TRIG_CMP1    = 3'h2;
  localparam logic [2:0] TRIG_CMP2    = 3'h3;
  localparam logic [2:0] TRIG_ANY_CMP = 3'h4;
  localparam logic [2:0] TRIG_PERIOD  = 3'h5;
  localparam logic [2:0] TRIG_ZERO_UP = 3'h6;
  localparam logic [2:0] TRIG_HALL    = 3'h7;
  // Direction qualifier codes
  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_UP   = 2'h1;
  localparam logic [1:0] DIR_DOWN = 2'h2;
  localparam logic [1:0] DIR_ANY  = 2'h3;
  // Extra divider is 2**8 = 256
  localparam logic [3:0] EXTRA_DIV_LOG2 = 4'h8;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== logic/aux_prescaler.sv
// Tick prescaler for the auxiliary timer: one-cycle tick every N clocks.
// Assumes run comes from the run flag; held in reset while it is low.
`timescale 1ns/10ps
module aux_prescaler
  import aux_timer_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [2:0] aux_clk_select,
  input  wire logic       aux_extra_div_en,
  output logic            aux_tick
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        tick_q;
  wire  [3:0]  shift_amt;
  wire  [15:0] div_n;
  wire  [15:0] term;
  wire         at_term;

  // Divide by 2**sel, times 256 with the extra divider
  assign shift_amt = {1'b0, aux_clk_select} + (aux_extra_div_en ? EXTRA_DIV_LOG2 : 4'h0);
  assign div_n     = 16'h0001 << shift_amt;
  assign term      = div_n - 16'h0001;
  assign at_term   = (cnt_q == term);
  // Stopped timer clears phase so every start is reproducible
  assign cnt_d     = (!run || at_term) ? 16'h0000 : cnt_q + 16'h0001;

  // Tick is a clock-domain enable, not a derived clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= run & at_term;
    end
  end
  assign aux_tick = tick_q;
endmodule

// ===== logic/aux_timer.sv
// Auxiliary 16-bit up-count timer with period/compare shadows and
// main-timer triggered start, registers on an AXI4-Lite slave.
// Assumes main-timer event inputs are one-cycle pulses on aclk.
//
// What this block does
// - Tick is module clock divided by 2**select, times 256 with extra divider.
// - Prescaler is held in reset while the timer is stopped.
// - One period lasts period value plus one ticks.
// - Count writes ignored while running, take effect at once when stopped.
// - Counter counts up, returns to zero on the tick after period match.
// - Shadow request set and cleared by write-one set and clear bits.
// - With request set, transfer on wrap after match or while stopped.
// - Transfer copies shadow period and shadow compare into active registers.
// - Writing one to run-set sets the run flag and starts counting.
// - Writing one to run-clear clears the run flag and halts counting.
// - Counter-clear zeroes the count and leaves the run flag alone.
// - Single-shot clears the run flag when the counter wraps after match.
// - Selected, direction-qualified main-timer event sets the run flag.
// - Trigger select picks none, channel compares, any compare, period, zero-up, hall.
// - The trigger is qualified by the main timer count direction.
// - Qualifier: none, only counting up, only counting down, or either.
// - Zero-match indication is true while the count is zero.
// - Period address writes shadow, reads the active period.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module aux_timer
  import aux_timer_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [2:0]  main_cmp_evt,
  input  wire logic        main_period_match,
  input  wire logic        main_zero_match,
  input  wire logic        main_count_down,
  input  wire logic        hall_change,
  output logic             aux_run_flag,
  output logic             aux_zero_match,
  output logic             aux_period_match,
  output logic             aux_compare_match,
  output logic             aux_shadow_xfer
);
  // Bus channel state
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic        aw_have_q, w_have_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0]  wr_strb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // Timer state
  logic [9:0]  ctrl_q;
  logic [15:0] count_q, count_d;
  logic [15:0] period_q, period_d, period_shd_q;
  logic [15:0] cmp_q, cmp_d, cmp_shd_q;
  logic        run_q, run_d, shd_req_q, shd_req_d;
  logic        zm_q, pm_q, cm_q, xfer_q;
  logic        aux_tick;
  logic [15:0] stat_w;

  // Write-side handshakes: address and data taken in either order
  wire aw_take  = s_axi_awvalid & awready_q;
  wire w_take   = s_axi_wvalid & wready_q;
  wire wr_fire  = aw_have_q & w_have_q & ~bvalid_q;
  wire aw_have_d = (aw_have_q | aw_take) & ~wr_fire;
  wire w_have_d  = (w_have_q | w_take) & ~wr_fire;
  wire bvalid_d  = wr_fire | (bvalid_q & ~s_axi_bready);
  wire ar_take   = s_axi_arvalid & arready_q;
  wire rvalid_d  = ar_take | (rvalid_q & ~s_axi_rready);

  // Write decode on the held address
  wire [7:0] wr_word = {wr_addr_q[7:2], 2'b00};
  wire wr_ctrl   = wr_fire & (wr_word == OFS_CTRL);
  wire wr_cmd    = wr_fire & (wr_word == OFS_CMD) & wr_strb_q[0];
  wire wr_count  = wr_fire & (wr_word == OFS_COUNT);
  wire wr_period = wr_fire & (wr_word == OFS_PERIOD);
  wire wr_cmpshd = wr_fire & (wr_word == OFS_CMP_SHD);
  wire wr_hit    = (wr_word == OFS_CTRL) | (wr_word == OFS_CMD)
                 | (wr_word == OFS_STAT) | (wr_word == OFS_COUNT)
                 | (wr_word == OFS_PERIOD) | (wr_word == OFS_CMP)
                 | (wr_word == OFS_CMP_SHD);

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  wire [15:0] ctrl_m   = merge16({6'h00, ctrl_q}, wr_data_q, wr_strb_q);
  wire [15:0] count_m  = merge16(count_q, wr_data_q, wr_strb_q);
  wire [15:0] per_m    = merge16(period_shd_q, wr_data_q, wr_strb_q);
  wire [15:0] cmpshd_m = merge16(cmp_shd_q, wr_data_q, wr_strb_q);

  // Command strobes are write-one pulses, zero bits do nothing
  wire [4:0] cmd = wr_cmd ? wr_data_q[4:0] : 5'h00;
  wire cmd_run_set = cmd[CMD_RUN_SET];
  wire cmd_run_clr = cmd[CMD_RUN_CLR];
  wire cmd_cnt_clr = cmd[CMD_CNT_CLR];
  wire cmd_shd_set = cmd[CMD_SHD_SET];
  wire cmd_shd_clr = cmd[CMD_SHD_CLR];

  // Control fields
  wire [2:0] aux_clk_select    = ctrl_q[CTL_SEL_LSB +: 3];
  wire       aux_extra_div_en  = ctrl_q[CTL_DIV_BIT];
  wire       aux_single_shot   = ctrl_q[CTL_SS_BIT];
  wire [2:0] aux_trig_select   = ctrl_q[CTL_TRIG_LSB +: 3];
  wire [1:0] aux_trig_dir_qual = ctrl_q[CTL_DIR_LSB +: 2];

  // Tick prescaler, reset while stopped
  aux_prescaler u_presc (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .run              (run_q),
    .aux_clk_select   (aux_clk_select),
    .aux_extra_div_en (aux_extra_div_en),
    .aux_tick         (aux_tick)
  );

  // Counting happens only on a tick while running
  wire run_tick   = aux_tick & run_q;
  wire period_hit = (count_q == period_q);
  wire wrap       = run_tick & period_hit;

  // Main-timer event selection
  wire trig_evt =
      (aux_trig_select == TRIG_CMP0)    ? main_cmp_evt[0] :
      (aux_trig_select == TRIG_CMP1)    ? main_cmp_evt[1] :
      (aux_trig_select == TRIG_CMP2)    ? main_cmp_evt[2] :
      (aux_trig_select == TRIG_ANY_CMP) ? |main_cmp_evt :
      (aux_trig_select == TRIG_PERIOD)  ? main_period_match :
      (aux_trig_select == TRIG_ZERO_UP) ? main_zero_match & ~main_count_down :
      (aux_trig_select == TRIG_HALL)    ? hall_change : 1'b0;
  // Direction gate; qualifier none blocks every trigger
  wire dir_ok = ((aux_trig_dir_qual == DIR_UP)   & ~main_count_down)
              | ((aux_trig_dir_qual == DIR_DOWN) &  main_count_down)
              |  (aux_trig_dir_qual == DIR_ANY);
  wire hw_trig = trig_evt & dir_ok;

  // Run flag: a set in the same cycle as a clear wins
  wire run_set = cmd_run_set | hw_trig;
  wire run_clr = cmd_run_clr | (wrap & aux_single_shot);
  assign run_d = (run_q & ~run_clr) | run_set;

  // Shadow request flag, set wins over clear
  assign shd_req_d = (shd_req_q & ~cmd_shd_clr) | cmd_shd_set;
  // Transfer at the wrap after match, or whenever stopped
  wire xfer_d = shd_req_q & (wrap | ~run_q);
  assign period_d = xfer_d ? period_shd_q : period_q;
  assign cmp_d    = xfer_d ? cmp_shd_q : cmp_q;

  // Counter: clear beats a stopped-time write beats the tick
  always_comb begin
    count_d = count_q;
    if (cmd_cnt_clr) begin
      count_d = 16'h0000;
    end else if (wr_count && !run_q) begin
      count_d = count_m;
    end else if (run_tick) begin
      // Zero follows the match, so one period is value plus one ticks
      count_d = period_hit ? 16'h0000 : count_q + 16'h0001;
    end
  end

  // Status view of the block's own state
  always_comb begin
    stat_w         = 16'h0000;
    stat_w[ST_RUN] = run_q;
    stat_w[ST_SHD] = shd_req_q;
    stat_w[ST_ZM]  = zm_q;
    stat_w[ST_PM]  = pm_q;
    stat_w[ST_CM]  = cm_q;
  end

  // Read decode straight from the request address
  wire [7:0] rd_word = {s_axi_araddr[7:2], 2'b00};
  wire rd_hit = (rd_word == OFS_CTRL) | (rd_word == OFS_CMD)
              | (rd_word == OFS_STAT) | (rd_word == OFS_COUNT)
              | (rd_word == OFS_PERIOD) | (rd_word == OFS_CMP)
              | (rd_word == OFS_CMP_SHD);
  // Period reads show the active value, not the shadow
  wire [15:0] rd_val =
      (rd_word == OFS_CTRL)    ? {6'h00, ctrl_q} :
      (rd_word == OFS_STAT)    ? stat_w :
      (rd_word == OFS_COUNT)   ? count_q :
      (rd_word == OFS_PERIOD)  ? period_q :
      (rd_word == OFS_CMP)     ? cmp_q :
      (rd_word == OFS_CMP_SHD) ? cmp_shd_q : 16'h0000;

  // Bus channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
      wr_addr_q <= 8'h00;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready_q <= ~aw_have_d & ~bvalid_d;
      wready_q  <= ~w_have_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (aw_take) begin
        wr_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (ar_take) begin
        rdata_q <= {16'h0000, rd_val};
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Software-written storage; period writes land in the shadow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q       <= RST_CTRL;
      period_shd_q <= RST_VAL16;
      cmp_shd_q    <= RST_VAL16;
    end else begin
      if (wr_ctrl) ctrl_q <= ctrl_m[9:0];
      if (wr_period) period_shd_q <= per_m;
      if (wr_cmpshd) cmp_shd_q <= cmpshd_m;
    end
  end

  // Timer core registers; flags follow the next-state values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q   <= RST_VAL16;
      period_q  <= RST_VAL16;
      cmp_q     <= RST_VAL16;
      run_q     <= 1'b0;
      shd_req_q <= 1'b0;
      xfer_q    <= 1'b0;
      zm_q      <= 1'b1;
      pm_q      <= 1'b1;
      cm_q      <= 1'b1;
    end else begin
      count_q   <= count_d;
      period_q  <= period_d;
      cmp_q     <= cmp_d;
      run_q     <= run_d;
      shd_req_q <= shd_req_d;
      xfer_q    <= xfer_d;
      zm_q      <= (count_d == 16'h0000);
      pm_q      <= (count_d == period_d);
      cm_q      <= (count_d == cmp_d);
    end
  end

  assign s_axi_awready     = awready_q;
  assign s_axi_wready      = wready_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_arready     = arready_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rresp       = rresp_q;
  assign s_axi_rdata       = rdata_q;
  assign aux_run_flag      = run_q;
  assign aux_zero_match    = zm_q;
  assign aux_period_match  = pm_q;
  assign aux_compare_match = cm_q;
  // Pulse is seen in the same cycle as the copy it reports
  assign aux_shadow_xfer   = xfer_q;

  // Checks on the timer behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  presc_hold_a: assert property (!run_q |=> !aux_tick)
    else $error("tick while stopped");
  tick_gap_a: assert property (aux_tick && aux_clk_select != 3'h0
      && $stable(ctrl_q) |=> !aux_tick)
    else $error("ticks too close");
  wrap_zero_a: assert property (wrap && !cmd_cnt_clr
      |=> count_q == 16'h0000)
    else $error("no wrap after period match");
  count_inc_a: assert property (run_tick && !period_hit && !cmd_cnt_clr
      |=> count_q == $past(count_q) + 16'h0001)
    else $error("count did not step");
  run_write_a: assert property (run_q && !run_tick && !cmd_cnt_clr
      |=> count_q == $past(count_q))
    else $error("count changed while running without tick");
  stop_write_a: assert property (wr_count && !run_q && !cmd_cnt_clr
      |=> count_q == $past(count_m))
    else $error("stopped write not taken");
  cnt_clr_a: assert property (cmd_cnt_clr && !run_set && !run_clr
      |=> count_q == 16'h0000 && run_q == $past(run_q))
    else $error("counter clear misbehaved");
  xfer_copy_a: assert property (shd_req_q && !run_q
      |=> period_q == $past(period_shd_q) && cmp_q == $past(cmp_shd_q)
          && aux_shadow_xfer)
    else $error("shadow copy missing");
  no_xfer_a: assert property (!shd_req_q
      |=> $stable(period_q) && $stable(cmp_q))
    else $error("transfer without request");
  shd_flag_a: assert property (cmd_shd_set |=> shd_req_q)
    else $error("request not set");
  shd_clr_a: assert property (cmd_shd_clr && !cmd_shd_set
      |=> !shd_req_q)
    else $error("request not cleared");
  run_set_a: assert property (cmd_run_set |=> run_q)
    else $error("run set ignored");
  run_clr_a: assert property (cmd_run_clr && !run_set |=> !run_q)
    else $error("run clear ignored");
  single_shot_a: assert property (wrap && aux_single_shot && !run_set
      |=> !run_q ##1 !aux_tick)
    else $error("single shot did not stop");
  trig_start_a: assert property (hw_trig |=> run_q)
    else $error("trigger did not start");
  dir_none_a: assert property (!run_q && aux_trig_dir_qual == DIR_NONE
      && !cmd_run_set |=> !run_q)
    else $error("start with qualifier none");
  zero_flag_a: assert property (aux_zero_match == (count_q == 16'h0000))
    else $error("zero match wrong");
  bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  ss_wrap_c: cover property (wrap && aux_single_shot ##1 !run_q);
  hw_start_c: cover property (!run_q && hw_trig ##1 run_q);
  run_xfer_c: cover property (run_q && shd_req_q && wrap);
endmodule

// ===== verification/main_timer_model.sv
// Event source standing in for the main timer beside the auxiliary timer.
// Assumes the bench raises go for one cycle; the event leaves one edge later.
`timescale 1ns/10ps
module main_timer_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go,
  input  wire logic [2:0] which,
  input  wire logic       down,
  output logic [2:0]      main_cmp_evt,
  output logic            main_period_match,
  output logic            main_zero_match,
  output logic            main_count_down,
  output logic            hall_change
);
  // Single-cycle event pulses, quiet between events like the real counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_cmp_evt      <= 3'h0;
      main_period_match <= 1'b0;
      main_zero_match   <= 1'b0;
      hall_change       <= 1'b0;
      main_count_down   <= 1'b0;
    end else begin
      main_cmp_evt      <= (go && which < 3'h3) ? 3'(3'h1 << which) : 3'h0;
      main_period_match <= go && which == 3'h3;
      main_zero_match   <= go && which == 3'h4;
      hall_change       <= go && which == 3'h5;
      main_count_down   <= down; // Direction is a level, not a pulse
    end
  end
endmodule

// ===== verification/aux_timer_tb.sv
// Self-checking bench for the auxiliary timer over its AXI4-Lite slave.
// Assumes the main timer model as event source and a 250 MHz aclk.
`timescale 1ns/10ps
module aux_timer_tb;
  import aux_timer_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  main_cmp_evt, which;
  logic        main_period_match, main_zero_match, main_count_down, hall_change;
  logic        aux_run_flag, aux_zero_match, aux_period_match, aux_compare_match;
  logic        aux_shadow_xfer, go, down;
  logic [31:0] v, w;
  logic [1:0]  r;
  int          error_cnt, n_checks, len0, len1, lens[8];

  aux_timer aux_timer_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .main_cmp_evt, .main_period_match,
    .main_zero_match, .main_count_down, .hall_change, .aux_run_flag, .aux_zero_match,
    .aux_period_match, .aux_compare_match, .aux_shadow_xfer);
  main_timer_model main_timer_model_i (.aclk, .aresetn, .go, .which, .down, .main_cmp_evt,
    .main_period_match, .main_zero_match, .main_count_down, .hall_change);

  // Free-running clock, 4 ns period
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic conclude();
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic give_up();
    error_cnt++;
    $display("wrong value timeout: no answer from the block");
    conclude();
  endtask

  // Write: AW and W offered together, bready held until bvalid is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 100) give_up();
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 100) give_up();
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Cycles the run flag stays high after a run-set command
  task automatic run_len(output int len);
    int n;
    n = 0;
    wr(OFS_CMD, 32'h1, r);
    while (aux_run_flag !== 1'b1) begin
      @(posedge aclk);
      if (++n > 50) give_up();
    end
    len = 0;
    while (aux_run_flag === 1'b1) begin
      @(posedge aclk);
      if (++len > 70000) give_up();
    end
  endtask

  task automatic sc_reset_bus();
    rd(OFS_CTRL, v, r); check("ctrl reset", v, 32'h0);
    rd(OFS_STAT, v, r); check("stat reset", v, 32'h1C);
    wr(8'h40, 32'h1, r); check("unmapped write resp", 32'(r), 32'(RESP_SLVERR));
    rd(8'h40, v, r); check("unmapped read resp", 32'(r), 32'(RESP_SLVERR));
  endtask

  task automatic sc_count();
    wr(OFS_COUNT, 32'h1234, r); rd(OFS_COUNT, v, r); check("count stopped", v, 32'h1234);
    check("zero match off", 32'(aux_zero_match), 32'h0);
    wr(OFS_CMD, 32'h4, r); check("zero match on", 32'(aux_zero_match), 32'h1);
    wr(OFS_PERIOD, 32'hFFFF, r); wr(OFS_CMD, 32'h8, r); wr(OFS_CMD, 32'h10, r);
    wr(OFS_CMD, 32'h1, r); wr(OFS_COUNT, 32'h0100, r); rd(OFS_COUNT, v, r);
    check("count write ignored", 32'(v < 32'h0100), 32'h1);
    wr(OFS_CMD, 32'h4, r); rd(OFS_STAT, v, r); check("run kept", 32'(v[ST_RUN]), 32'h1);
    wr(OFS_CMD, 32'h2, r); rd(OFS_COUNT, v, r); repeat (10) @(posedge aclk);
    rd(OFS_COUNT, w, r); check("halted", w, v);
    wr(OFS_CMD, 32'h4, r);
  endtask

  task automatic sc_shadow();
    wr(OFS_PERIOD, 32'h5, r); rd(OFS_PERIOD, v, r); check("active period", v, 32'hFFFF);
    wr(OFS_CMP_SHD, 32'h7, r); wr(OFS_CMD, 32'h8, r);
    rd(OFS_STAT, v, r); check("shadow req", 32'(v[ST_SHD]), 32'h1);
    rd(OFS_PERIOD, v, r); check("period xfer", v, 32'h5);
    rd(OFS_CMP, v, r); check("compare xfer", v, 32'h7);
    check("xfer while stopped", 32'(aux_shadow_xfer), 32'h1);
    wr(OFS_COUNT, 32'h5, r); check("period match", 32'(aux_period_match), 32'h1);
    check("no compare match", 32'(aux_compare_match), 32'h0);
    wr(OFS_COUNT, 32'h7, r); check("compare match", 32'(aux_compare_match), 32'h1);
    check("no period match", 32'(aux_period_match), 32'h0);
    // Count clear rides along so the next run starts from zero
    wr(OFS_CMD, 32'h14, r); rd(OFS_STAT, v, r); check("req clr", 32'(v[ST_SHD]), 32'h0);
    check("no xfer", 32'(aux_shadow_xfer), 32'h0);
    wr(OFS_PERIOD, 32'h1, r); wr(OFS_CTRL, 32'h0, r); wr(OFS_CMD, 32'h1, r);
    wr(OFS_CMD, 32'h8, r); repeat (20) @(posedge aclk);
    rd(OFS_PERIOD, v, r); check("xfer at wrap", v, 32'h1);
    wr(OFS_CMD, 32'h12, r); wr(OFS_CMD, 32'h4, r);
  endtask

  // Run lengths differ only by the tick rate, since the prescaler phase resets
  task automatic sc_prescale();
    for (int s = 0; s < 8; s++) begin
      wr(OFS_CTRL, 32'h10 | s, r); run_len(lens[s]);
      check("tick divide", lens[s] - lens[0], ((1 << s) - 1) * 2);
    end
    rd(OFS_COUNT, v, r); check("single shot end", v, 32'h0);
    wr(OFS_CTRL, 32'h11, r); run_len(len1); check("repeatable", len1, lens[1]);
    wr(OFS_CTRL, 32'h18, r); run_len(len0); check("extra divide", len0 - lens[0], 510);
  endtask

  task automatic trig_case(input logic [2:0] t, input logic [1:0] d, input logic [2:0] k,
                           input logic dn, input logic e);
    wr(OFS_CTRL, 32'({d, t, 5'h0}), r);
    down <= dn;
    @(posedge aclk); go <= 1'b1; which <= k;
    @(posedge aclk); go <= 1'b0;
    repeat (4) @(posedge aclk);
    check("trigger start", 32'(aux_run_flag), 32'(e));
    wr(OFS_CMD, 32'h2, r);
  endtask

  task automatic sc_trig();
    trig_case(TRIG_CMP0, DIR_ANY, 3'h0, 1'b0, 1'b1);
    trig_case(TRIG_CMP1, DIR_ANY, 3'h1, 1'b1, 1'b1);
    trig_case(TRIG_CMP2, DIR_ANY, 3'h2, 1'b0, 1'b1);
    trig_case(TRIG_ANY_CMP, DIR_ANY, 3'h1, 1'b0, 1'b1);
    trig_case(TRIG_PERIOD, DIR_ANY, 3'h3, 1'b0, 1'b1);
    trig_case(TRIG_ZERO_UP, DIR_ANY, 3'h4, 1'b0, 1'b1);
    trig_case(TRIG_HALL, DIR_ANY, 3'h5, 1'b1, 1'b1);
    trig_case(TRIG_NONE, DIR_ANY, 3'h3, 1'b0, 1'b0);
    trig_case(TRIG_CMP0, DIR_ANY, 3'h1, 1'b0, 1'b0);
    trig_case(TRIG_ZERO_UP, DIR_ANY, 3'h4, 1'b1, 1'b0);
    trig_case(TRIG_PERIOD, DIR_NONE, 3'h3, 1'b0, 1'b0);
    trig_case(TRIG_PERIOD, DIR_UP, 3'h3, 1'b1, 1'b0);
    trig_case(TRIG_PERIOD, DIR_UP, 3'h3, 1'b0, 1'b1);
    trig_case(TRIG_PERIOD, DIR_DOWN, 3'h3, 1'b1, 1'b1);
    trig_case(TRIG_PERIOD, DIR_DOWN, 3'h3, 1'b0, 1'b0);
  endtask

  // Main sequence: reset for 8 cycles, then the scenarios in turn
  initial begin
    aresetn = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF; go = 1'b0; which = 3'h0; down = 1'b0;
    error_cnt = 0; n_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    sc_reset_bus();
    sc_count();
    sc_shadow();
    sc_prescale();
    sc_trig();
    conclude();
  end
endmodule
